// ==== core/llb_top.sv ====
// LED link and behaviour control with AXI4-Lite register slave
//
// The implementer's own choice: register access over AXI4-Lite.
`include "llb_defs.svh"
module llb_top
  import llb_pkg::*;
#(
  parameter int NUM_CH       = 8,
  parameter int PWM_STEP_CYC = `LLB_PWM_STEP_CYC
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [NUM_CH-1:0] sense_input,
  output logic [NUM_CH-1:0]      led_pin
);
  // ============================================================
  // Elaboration checks
  if (NUM_CH != 8)
  begin : g_bad_ch
    $error("llb_top serves exactly eight channels");
  end
  if (PWM_STEP_CYC < 1 || PWM_STEP_CYC > 65535)
  begin : g_bad_step
    $error("llb_top PWM step count out of range");
  end

  // ============================================================
  // Declarations
  logic [7:0]  cfg_r, cfg_nxt, link_r, link_nxt, pol_r, pol_nxt, host_r, host_nxt;
  logic [7:0]  ltran_r, ltran_nxt, mirror_r, mirror_nxt, beh_lo_r, beh_lo_nxt;
  logic [7:0]  beh_hi_r, beh_hi_nxt, duty_r, duty_nxt, period_r, period_nxt;
  logic [7:0]  pulses_r, pulses_nxt;
  logic        aw_held_r, aw_held_nxt, w_held_r, w_held_nxt, bvalid_r, bvalid_nxt;
  logic [7:0]  awidx_r, awidx_nxt, wbyte_r, wbyte_nxt;
  logic        awhi_r, awhi_nxt, wlane_r, wlane_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [7:0]  sync1_r, sync2_r, sync3_r, touch_r, touch_nxt;
  logic [15:0] tick_cnt_r, tick_cnt_nxt;
  logic        pwm_tick;
  logic [7:0]  actuated, pins;
  logic [15:0] beh_all;
  logic        do_write, wr_hit, rd_hit;
  logic [7:0]  rd_byte, rd_idx, pol_changed;

  // ============================================================
  // Sense input synchroniser with agreement filter
  always_comb
  begin
    touch_nxt = touch_r;
    for (int i = 0; i < 8; i++)
    begin
      if (sync2_r[i] == sync3_r[i]) touch_nxt[i] = sync3_r[i];
    end
  end

  // Synchroniser and filter registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
      sync3_r <= 8'h00;
      touch_r <= 8'h00;
    end
    else
    begin
      sync1_r <= sense_input;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      touch_r <= touch_nxt;
    end
  end

  // ============================================================
  // PWM slot divider
  always_comb
  begin
    pwm_tick     = (tick_cnt_r == 16'(PWM_STEP_CYC - 1));
    tick_cnt_nxt = pwm_tick ? 16'h0000 : tick_cnt_r + 16'h0001;
  end

  // Divider register
  always_ff @(posedge aclk)
  begin
    if (!aresetn) tick_cnt_r <= 16'h0000;
    else tick_cnt_r <= tick_cnt_nxt;
  end

  // ============================================================
  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready  = !w_held_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign do_write      = aw_held_r && w_held_r && !bvalid_r;
  assign pol_changed   = wbyte_r ^ pol_r;

  // Write decode and register update
  always_comb
  begin
    aw_held_nxt = aw_held_r;
    w_held_nxt  = w_held_r;
    awidx_nxt   = awidx_r;
    awhi_nxt    = awhi_r;
    wbyte_nxt   = wbyte_r;
    wlane_nxt   = wlane_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    cfg_nxt     = cfg_r;
    link_nxt    = link_r;
    pol_nxt     = pol_r;
    host_nxt    = host_r;
    ltran_nxt   = ltran_r;
    mirror_nxt  = mirror_r;
    beh_lo_nxt  = beh_lo_r;
    beh_hi_nxt  = beh_hi_r;
    duty_nxt    = duty_r;
    period_nxt  = period_r;
    pulses_nxt  = pulses_r;
    wr_hit      = 1'b1;
    if (s_axi_awvalid && !aw_held_r)
    begin
      aw_held_nxt = 1'b1;
      awidx_nxt   = s_axi_awaddr[9:2];
      awhi_nxt    = (s_axi_awaddr[11:10] != 2'h0);
    end
    if (s_axi_wvalid && !w_held_r)
    begin
      w_held_nxt = 1'b1;
      wbyte_nxt  = s_axi_wdata[7:0];
      wlane_nxt  = s_axi_wstrb[0];
    end
    if (bvalid_r && s_axi_bready) bvalid_nxt = 1'b0;
    if (do_write)
    begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      if (awhi_r) wr_hit = 1'b0;
      else if (awidx_r == `LLB_IDX_CONFIG)
      begin
        if (wlane_r) cfg_nxt = wbyte_r & 8'h03;
      end
      else if (awidx_r == `LLB_IDX_LINK)
      begin
        if (wlane_r) link_nxt = wbyte_r;
      end
      else if (awidx_r == `LLB_IDX_POL)
      begin
        if (wlane_r)
        begin
          pol_nxt = wbyte_r;
          if (!cfg_r[`LLB_CFG_BLK_MIR])
            mirror_nxt = (mirror_r & ~pol_changed) | (wbyte_r & pol_changed);
        end
      end
      else if (awidx_r == `LLB_IDX_HOST)
      begin
        if (wlane_r) host_nxt = wbyte_r;
      end
      else if (awidx_r == `LLB_IDX_LTRAN)
      begin
        if (wlane_r) ltran_nxt = wbyte_r;
      end
      else if (awidx_r == `LLB_IDX_MIRROR)
      begin
        if (wlane_r) mirror_nxt = wbyte_r;
      end
      else if (awidx_r == `LLB_IDX_BEH_LO)
      begin
        if (wlane_r) beh_lo_nxt = wbyte_r;
      end
      else if (awidx_r == `LLB_IDX_BEH_HI)
      begin
        if (wlane_r) beh_hi_nxt = wbyte_r;
      end
      else if (awidx_r == `LLB_IDX_DUTY)
      begin
        if (wlane_r) duty_nxt = wbyte_r;
      end
      else if (awidx_r == `LLB_IDX_PERIOD)
      begin
        if (wlane_r) period_nxt = wbyte_r & 8'h0f;
      end
      else if (awidx_r == `LLB_IDX_PULSES)
      begin
        if (wlane_r) pulses_nxt = wbyte_r & 8'h0f;
      end
      else if (awidx_r != `LLB_IDX_STATUS) wr_hit = 1'b0;
      bresp_nxt = wr_hit ? `LLB_RESP_OKAY : `LLB_RESP_SLVERR;
    end
  end

  // Write channel and configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awidx_r   <= 8'h00;
      awhi_r    <= 1'b0;
      wbyte_r   <= 8'h00;
      wlane_r   <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `LLB_RESP_OKAY;
      cfg_r     <= `LLB_RST_ZERO;
      link_r    <= `LLB_RST_ZERO;
      pol_r     <= `LLB_RST_ZERO;
      host_r    <= `LLB_RST_ZERO;
      ltran_r   <= `LLB_RST_ZERO;
      mirror_r  <= `LLB_RST_ZERO;
      beh_lo_r  <= `LLB_RST_ZERO;
      beh_hi_r  <= `LLB_RST_ZERO;
      duty_r    <= `LLB_RST_DUTY;
      period_r  <= `LLB_RST_PERIOD;
      pulses_r  <= `LLB_RST_PULSES;
    end
    else
    begin
      aw_held_r <= aw_held_nxt;
      w_held_r  <= w_held_nxt;
      awidx_r   <= awidx_nxt;
      awhi_r    <= awhi_nxt;
      wbyte_r   <= wbyte_nxt;
      wlane_r   <= wlane_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      cfg_r     <= cfg_nxt;
      link_r    <= link_nxt;
      pol_r     <= pol_nxt;
      host_r    <= host_nxt;
      ltran_r   <= ltran_nxt;
      mirror_r  <= mirror_nxt;
      beh_lo_r  <= beh_lo_nxt;
      beh_hi_r  <= beh_hi_nxt;
      duty_r    <= duty_nxt;
      period_r  <= period_nxt;
      pulses_r  <= pulses_nxt;
    end
  end

  // ============================================================
  // Read channel: one cycle to answer, held until taken
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign rd_idx        = s_axi_araddr[9:2];

  // Read decode
  always_comb
  begin
    rd_hit  = (s_axi_araddr[11:10] == 2'h0);
    rd_byte = 8'h00;
    if (!rd_hit) rd_byte = 8'h00;
    else if (rd_idx == `LLB_IDX_CONFIG) rd_byte = cfg_r;
    else if (rd_idx == `LLB_IDX_LINK) rd_byte = link_r;
    else if (rd_idx == `LLB_IDX_POL) rd_byte = pol_r;
    else if (rd_idx == `LLB_IDX_HOST) rd_byte = host_r;
    else if (rd_idx == `LLB_IDX_LTRAN) rd_byte = ltran_r;
    else if (rd_idx == `LLB_IDX_MIRROR) rd_byte = mirror_r;
    else if (rd_idx == `LLB_IDX_BEH_LO) rd_byte = beh_lo_r;
    else if (rd_idx == `LLB_IDX_BEH_HI) rd_byte = beh_hi_r;
    else if (rd_idx == `LLB_IDX_DUTY) rd_byte = duty_r;
    else if (rd_idx == `LLB_IDX_PERIOD) rd_byte = period_r;
    else if (rd_idx == `LLB_IDX_PULSES) rd_byte = pulses_r;
    else if (rd_idx == `LLB_IDX_STATUS) rd_byte = actuated;
    else rd_hit = 1'b0;
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rvalid_r && s_axi_rready) rvalid_nxt = 1'b0;
    if (s_axi_arvalid && !rvalid_r)
    begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = {24'h000000, rd_byte};
      rresp_nxt  = rd_hit ? `LLB_RESP_OKAY : `LLB_RESP_SLVERR;
    end
  end

  // Read channel registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= `LLB_RESP_OKAY;
    end
    else
    begin
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
    end
  end

  // ============================================================
  // Channel array, one engine per LED
  assign beh_all = {beh_hi_r, beh_lo_r};
  assign led_pin = pins;

  for (genvar i = 0; i < 8; i++)
  begin : g_ch
    llb_chan_if cif ();
    // Per-channel slice of the shared configuration
    assign cif.linked   = link_r[i];
    assign cif.ltran    = ltran_r[i];
    assign cif.inv_link = cfg_r[`LLB_CFG_INV_LINK];
    assign cif.host_bit = host_r[i];
    assign cif.touch    = touch_r[i];
    assign cif.behavior = beh_all[2*i+1 -: 2];
    assign cif.mirror   = mirror_r[i];
    assign cif.polarity = pol_r[i];
    assign cif.min_duty = duty_r[`LLB_DUTY_MIN_LSB +: 4];
    assign cif.max_duty = duty_r[`LLB_DUTY_MAX_LSB +: 4];
    assign cif.period   = period_r[3:0];
    assign cif.pulses   = pulses_r[3:0];
    assign cif.pwm_tick = pwm_tick;
    assign pins[i]      = cif.pin;
    assign actuated[i]  = cif.actuated;
    // Independent engine for this channel
    llb_channel u_ch
    (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ch      (cif.chan)
    );
  end
endmodule

// ==== core/llb_defs.svh ====
// Constants for the LED link and behaviour control block
// Summary of operation
// - With transition select clear, linking a channel whose host bit is one and whose sensor is untouched changes the LED.
// - With transition select set and invert-link-transition one, that linking keeps the LED and a later touch changes it.
// - With transition select set and invert-link-transition zero, that linking keeps the LED and later touches do not change it.
// - Transition select bit n-1 governs LED channel n paired with sense input n, bit 7 down to bit 0.
// - With duty mirror clear the minimum and maximum duty settings apply directly, relative to 0%.
// - With duty mirror set the minimum and maximum duty settings are taken relative to 100%.
// - Changing a polarity bit copies it into that channel's duty mirror bit unless block-polarity-mirror is set.
// - Each channel has a 2-bit behaviour field, channels one to four at 81h and five to eight at 82h, lowest first.
// - A linked channel starts and stops its behaviour from touch and release of its sense input.
// - An unlinked channel takes its host bit written to one as a touch and written to zero as a release.
// - A behaviour starts on its start trigger and stops on its stop trigger.
// - The pin level of a channel that is not actuated follows its polarity in direct and breathe behaviour; the pulse behaviours run their pulses on release;
//   here pulse behaviour code one starts its pulses on every change of actuation, touch as well as release.
// - The host bit of a linked channel is ignored.
// - Direct behaviour (code zero) drives the LED active or inactive following start and stop.
// - Breathe behaviour (code three) ramps min to max and back, each ramp half of the breathe period.
`ifndef LLB_DEFS_SVH
`define LLB_DEFS_SVH

// ============================================================
// Register indices (byte address is four times the index)
`define LLB_IDX_CONFIG   8'h44
`define LLB_IDX_LINK     8'h72
`define LLB_IDX_POL      8'h73
`define LLB_IDX_HOST     8'h74
`define LLB_IDX_LTRAN    8'h77
`define LLB_IDX_MIRROR   8'h79
`define LLB_IDX_BEH_LO   8'h81
`define LLB_IDX_BEH_HI   8'h82
`define LLB_IDX_DUTY     8'h90
`define LLB_IDX_PERIOD   8'h91
`define LLB_IDX_PULSES   8'h92
`define LLB_IDX_STATUS   8'h93

// ============================================================
// Field positions
`define LLB_CFG_INV_LINK 0
`define LLB_CFG_BLK_MIR  1
`define LLB_DUTY_MIN_LSB 0
`define LLB_DUTY_MAX_LSB 4

// ============================================================
// Reset values
`define LLB_RST_ZERO     8'h00
`define LLB_RST_DUTY     8'hf0
`define LLB_RST_PERIOD   8'h03
`define LLB_RST_PULSES   8'h02

// ============================================================
// Behaviour codes and bus responses
`define LLB_BEH_DIRECT   2'h0
`define LLB_BEH_PULSE1   2'h1
`define LLB_BEH_PULSE2   2'h2
`define LLB_BEH_BREATHE  2'h3
`define LLB_RESP_OKAY    2'h0
`define LLB_RESP_SLVERR  2'h2

// ============================================================
// Timing: one PWM slot per step time
`define LLB_CLK_PERIOD_NS 8
`define LLB_PWM_STEP_NS   1000
`define LLB_PWM_STEP_CYC  ((`LLB_PWM_STEP_NS) / (`LLB_CLK_PERIOD_NS))

`endif

// ==== core/llb_pkg.sv ====
// Types shared by the LED link and behaviour control block
package llb_pkg;
  // Behaviour sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_TAIL} llb_state_e;
  // Duty level in sixteenths
  typedef logic [3:0] llb_duty_t;
endpackage

// ==== core/llb_chan_if.sv ====
// Per-channel configuration and result bundle
interface llb_chan_if;
  import llb_pkg::*;
  logic      linked;
  logic      ltran;
  logic      inv_link;
  logic      host_bit;
  logic      touch;
  logic [1:0] behavior;
  logic      mirror;
  logic      polarity;
  llb_duty_t min_duty;
  llb_duty_t max_duty;
  llb_duty_t period;
  llb_duty_t pulses;
  logic      pwm_tick;
  logic      pin;
  logic      actuated;
  modport ctrl (output linked, ltran, inv_link, host_bit, touch, behavior, mirror, polarity,
                output min_duty, max_duty, period, pulses, pwm_tick, input pin, actuated);
  modport chan (input linked, ltran, inv_link, host_bit, touch, behavior, mirror, polarity,
                input min_duty, max_duty, period, pulses, pwm_tick, output pin, actuated);
endinterface

// ==== core/llb_channel.sv ====
// One LED channel: link transition, behaviour sequencer and PWM output
`include "llb_defs.svh"
module llb_channel
  import llb_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  llb_chan_if.chan  ch
);
  logic       prev_link_r, prev_link_nxt, inv_r, inv_nxt, hold_r, hold_nxt;
  logic       act_r, act_nxt, up_r, up_nxt, pin_r, pin_nxt;
  llb_state_e state_r, state_nxt;
  llb_duty_t  level_r, level_nxt, pwm_r, pwm_nxt, div_r, div_nxt, left_r, left_nxt;
  llb_duty_t  duty, duty_eff;
  logic       frame_end, step, pulse_done;

  // ============================================================
  // Next-state logic
  always_comb
  begin
    prev_link_nxt = ch.linked;
    inv_nxt       = ch.linked ? inv_r : 1'b0;
    hold_nxt      = ch.linked ? hold_r : 1'b0;
    // Link edge with host bit on and no touch
    if (ch.linked && !prev_link_r && ch.host_bit && !ch.touch && ch.ltran)
    begin
      inv_nxt  = ch.inv_link;
      hold_nxt = !ch.inv_link;
    end
    // Actuation request from sensor or host bit
    if (ch.linked)
      act_nxt = hold_nxt ? 1'b1 : (ch.touch ^ inv_nxt);
    else
      act_nxt = ch.host_bit;
    pwm_nxt    = ch.pwm_tick ? pwm_r + 4'h1 : pwm_r;
    frame_end  = ch.pwm_tick && (pwm_r == 4'hf);
    div_nxt    = frame_end ? ((div_r == ch.period) ? 4'h0 : div_r + 4'h1) : div_r;
    step       = frame_end && (div_r == ch.period);
    state_nxt  = state_r;
    level_nxt  = level_r;
    up_nxt     = up_r;
    left_nxt   = left_r;
    pulse_done = 1'b0;
    // Ramp one duty step up or down between the limits
    if (step && state_r != ST_IDLE)
    begin
      if (up_r)
      begin
        if (level_r >= ch.max_duty) up_nxt = 1'b0;
        else level_nxt = level_r + 4'h1;
      end
      else if (level_r <= ch.min_duty)
      begin
        up_nxt     = 1'b1;
        pulse_done = 1'b1;
      end
      else level_nxt = level_r - 4'h1;
    end
    case (state_r)
      ST_IDLE:
      begin
        level_nxt = ch.min_duty;
        up_nxt    = 1'b1;
        if (ch.behavior == `LLB_BEH_PULSE1 && (act_nxt != act_r))
        begin
          state_nxt = ST_TAIL;
          left_nxt  = ch.pulses;
        end
        else if (act_nxt && (ch.behavior == `LLB_BEH_BREATHE || ch.behavior == `LLB_BEH_PULSE2))
          state_nxt = ST_RUN;
      end
      ST_RUN:
      begin
        if (ch.behavior == `LLB_BEH_DIRECT || ch.behavior == `LLB_BEH_PULSE1)
          state_nxt = ST_IDLE;
        else if (!act_nxt && ch.behavior == `LLB_BEH_PULSE2)
        begin
          state_nxt = ST_TAIL;
          left_nxt  = ch.pulses;
        end
        else if (!act_nxt)
          state_nxt = ST_IDLE;
      end
      default:
      begin
        if (pulse_done)
        begin
          left_nxt = left_r - 4'h1;
          if (left_r <= 4'h1) state_nxt = ST_IDLE;
        end
      end
    endcase
    // Direct follows actuation, others use the ramp level
    if (ch.behavior == `LLB_BEH_DIRECT)
      duty = act_r ? ch.max_duty : ch.min_duty;
    else
      duty = level_r;
    duty_eff = ch.mirror ? ~duty : duty;
    // Clear polarity sinks the LED, so on means a low pin
    pin_nxt  = ch.polarity ? (duty_eff > pwm_r) : !(duty_eff > pwm_r);
  end

  // ============================================================
  // State registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prev_link_r <= 1'b0;
      inv_r       <= 1'b0;
      hold_r      <= 1'b0;
      act_r       <= 1'b0;
      up_r        <= 1'b1;
      pin_r       <= 1'b1;
      state_r     <= ST_IDLE;
      level_r     <= 4'h0;
      pwm_r       <= 4'h0;
      div_r       <= 4'h0;
      left_r      <= 4'h0;
    end
    else
    begin
      prev_link_r <= prev_link_nxt;
      inv_r       <= inv_nxt;
      hold_r      <= hold_nxt;
      act_r       <= act_nxt;
      up_r        <= up_nxt;
      pin_r       <= pin_nxt;
      state_r     <= state_nxt;
      level_r     <= level_nxt;
      pwm_r       <= pwm_nxt;
      div_r       <= div_nxt;
      left_r      <= left_nxt;
    end
  end

  assign ch.pin      = pin_r;
  assign ch.actuated = act_r;
endmodule

// ==== test/llb_assertions.sv ====
// Bus handshake and pin checks for the LED behaviour block
module llb_assertions
#(
  parameter int NUM_CH = 8
)
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [NUM_CH-1:0] led_pin
);
  // ============
  // Properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read address taken early");
  property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_r_upper: assert property (p_r_upper) else $error("upper read lanes set");
  property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  property p_b_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
      |=> ##1 s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write answer late");
  property p_aw_block;
    s_axi_awvalid && s_axi_awready && !(s_axi_wvalid && s_axi_wready) |=> !s_axi_awready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("second address taken");
  property p_bresp; s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2}; endproperty
  a_bresp: assert property (p_bresp) else $error("bad write response");
  property p_rst;
    $rose(aresetn) |-> led_pin == '1 && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  // Main scenarios
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_lit: cover property (led_pin != '1);
endmodule

bind llb_top llb_assertions #(.NUM_CH(NUM_CH)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .led_pin(led_pin));

// ==== test/llb_led_model.sv ====
// Eight current-sinking LEDs that count their lit cycles
module llb_led_model
(
  input wire logic       aclk,
  input wire logic       clr,
  input wire logic [7:0] led_pin,
  output logic [31:0]    lit_cnt [8]
);
  timeunit 1ns;
  timeprecision 1ps;
  // A low pin sinks current and lights its LED; an unknown pin spoils the count
  always @(posedge aclk)
    for (int i = 0; i < 8; i++)
      lit_cnt[i] <= clr ? 32'h0 : lit_cnt[i] + 32'(!led_pin[i]);
endmodule

// ==== test/tb_top.sv ====
// Register-level testbench for the LED behaviour block
`include "llb_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] OK = `LLB_RESP_OKAY;
  localparam logic [7:0] REGS [4] = '{`LLB_IDX_LTRAN, `LLB_IDX_MIRROR,
                                      `LLB_IDX_BEH_LO, `LLB_IDX_BEH_HI};
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, clr;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [7:0]  sense, pins, v;
  logic [31:0] lit_cnt [8];
  int          failures, checked;
  // ============
  // Design and LEDs
  llb_top #(.PWM_STEP_CYC(1)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sense_input(sense), .led_pin(pins));
  llb_led_model u_leds (.aclk(aclk), .clr(clr), .led_pin(pins), .lit_cnt(lit_cnt));
  initial
  begin
    aclk = 0;
    forever #4 aclk = ~aclk;
  end
  // ============
  // Tasks
  task automatic chk(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n == 64)
    begin
      failures++;
      conclude();
    end
  endtask
  // Data may trail the address by lag edges; bready stays up after the answer
  task automatic wr(input logic [7:0] idx, d, input logic [1:0] er, input int lag = 0);
    int n;
    awaddr <= {2'h0, idx, 2'h0};
    awvalid <= 1;
    wdata <= {24'h0, d};
    wvalid <= (lag == 0);
    bready <= 1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge aclk);
      if (awready && awvalid) awvalid <= 0;
      if (wready && wvalid) wvalid <= 0;
      else if (n + 1 == lag) wvalid <= 1;
      if (bvalid) break;
    end
    tmo(n);
    chk(bresp, er);
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] d, input logic [1:0] er);
    int n;
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1;
    rready <= 1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    tmo(n);
    chk(rresp, er);
    d = rdata[7:0];
  endtask
  task automatic rc(input logic [7:0] idx, m, e);
    logic [7:0] d;
    rd(idx, d, OK);
    chk(d & m, e);
  endtask
  // Lit cycles of LEDs one and two over one 16-slot frame
  task automatic lit(input int e0, e1);
    clr <= 1;
    repeat (2) @(posedge aclk);
    clr <= 0;
    repeat (16) @(posedge aclk);
    #1;
    chk(lit_cnt[0], e0);
    chk(lit_cnt[1], e1);
  endtask
  // ============
  // Scenarios
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, clr} = '0;
    {awaddr, araddr, wdata, sense} = '0;
    wstrb = 4'hf;
    failures = 0;
    checked = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    foreach (REGS[i])
    begin
      rc(REGS[i], 8'hff, 8'h00);
      wr(REGS[i], 8'he4, OK);
      rc(REGS[i], 8'hff, 8'he4);
      wr(REGS[i], 8'h00, OK);
    end
    wr(8'h10, 8'h55, `LLB_RESP_SLVERR);
    rd(8'h10, v, `LLB_RESP_SLVERR);
    chk(v, 8'h00);
    wr(`LLB_IDX_DUTY, 8'hf0, OK, 1);
    wr(`LLB_IDX_HOST, 8'h01, OK);
    lit(15, 0);
    rc(`LLB_IDX_STATUS, 8'h01, 8'h01);
    wr(`LLB_IDX_HOST, 8'h00, OK);
    lit(0, 0);
    wr(`LLB_IDX_HOST, 8'h07, OK);
    wr(`LLB_IDX_LINK, 8'h01, OK);
    rc(`LLB_IDX_STATUS, 8'h01, 8'h00);
    sense[0] <= 1;
    repeat (8) @(posedge aclk);
    rc(`LLB_IDX_STATUS, 8'h01, 8'h01);
    wr(`LLB_IDX_HOST, 8'h06, OK);
    rc(`LLB_IDX_STATUS, 8'h01, 8'h01);
    sense[0] <= 0;
    repeat (8) @(posedge aclk);
    rc(`LLB_IDX_STATUS, 8'h01, 8'h00);
    wr(`LLB_IDX_CONFIG, 8'h01, OK);
    wr(`LLB_IDX_LTRAN, 8'h02, OK);
    wr(`LLB_IDX_LINK, 8'h03, OK);
    rc(`LLB_IDX_STATUS, 8'h02, 8'h02);
    sense[1] <= 1;
    repeat (8) @(posedge aclk);
    rc(`LLB_IDX_STATUS, 8'h02, 8'h00);
    wr(`LLB_IDX_CONFIG, 8'h00, OK);
    wr(`LLB_IDX_LTRAN, 8'h06, OK);
    wr(`LLB_IDX_LINK, 8'h07, OK);
    rc(`LLB_IDX_STATUS, 8'h04, 8'h04);
    sense[2] <= 1;
    repeat (8) @(posedge aclk);
    rc(`LLB_IDX_STATUS, 8'h04, 8'h04);
    wr(`LLB_IDX_POL, 8'h01, OK);
    rc(`LLB_IDX_MIRROR, 8'hff, 8'h01);
    wr(`LLB_IDX_CONFIG, 8'h02, OK);
    wr(`LLB_IDX_POL, 8'h03, OK);
    rc(`LLB_IDX_MIRROR, 8'hff, 8'h01);
    lit(1, 16);
    conclude();
  end
endmodule
